// file: design/isab_defs.vh
/*
 constants for the host-side expansion channel memory cycle sequencer.
 assumes a 50 MHz core clock; timing counts are in those cycles, but the wait counts are in bus clock falls.
*/
// What this block does
// - active-low zero-wait request from a card ends the cycle without further waits.
// - host starts 8-bit memory read/write commands on a bus clock falling edge.
// - host drives a free-running 14.31818 MHz, 50% duty oscillator output.
// - refresh indicator marks a refresh cycle; host or channel processor drives it.
// - host drives active-high channel reset at power-up and low-line outage.
// - twenty latched address lines plus unlatched 23..17 give 16MB addressing.
// - latched address placed while latch strobe high, held from its falling edge.
// - upper-byte enable asserted whenever data moves on bits 15..8.
// - low-memory read strobe only below 1MB, derived from general read strobe.
// - general active-low read strobe asserted on every memory read cycle.
// - low-memory write strobe only below 1MB; general write on all writes.
// - host pulses terminal-count output when any DMA channel hits terminal count.
// - host supplies a 50% duty bus clock meant for synchronisation only.
// - host forces the latch strobe high throughout DMA cycles.
`ifndef ISAB_DEFS_VH
`define ISAB_DEFS_VH
`define ISAB_CLK_HZ 50000000
`define ISAB_BCLK_HALF 3'h4
`define ISAB_OSC_NUM 20'h45E9C
`define ISAB_OSC_DEN 20'hF4240
`define ISAB_OSC_ACC_W 20
`define ISAB_WAIT8 4'h4
`define ISAB_WAIT16 4'h1
`define ISAB_LOW1MB_TOP 4'h0
`define ISAB_RST_HOLD 8'hFF
`endif

// file: design/isab_osc_gen.v
/*
 fractional oscillator generator for the free-running channel oscillator.
 assumes a 50 MHz clock; output jitters by one clock, duty settles at half.
*/
`timescale 1ns/1ps
`include "isab_defs.vh"
module isab_osc_gen (
	input wire clock,
	input wire rst,
	input wire clockEn,
	output reg oscOut
);
	// phase accumulator of twice the wanted rate, toggles on wrap
	reg [19:0] acc_r;
	reg [20:0] sum;
	always @* begin
		sum = {1'b0, acc_r} + {1'b0, `ISAB_OSC_NUM} + {1'b0, `ISAB_OSC_NUM};
	end
	always @(posedge clock) begin
		if (rst) begin
			acc_r <= 20'h00000;
			oscOut <= 1'b0;
		end else if (clockEn) begin
			if (sum >= {1'b0, `ISAB_OSC_DEN}) begin
				acc_r <= sum[19:0] - `ISAB_OSC_DEN;
				oscOut <= ~oscOut;
			end else begin
				acc_r <= sum[19:0];
			end
		end
	end
endmodule // isab_osc_gen

// file: design/isab_mem_cycle.v
/*
 host end of the expansion channel: bus clock, latch strobe, latched and
 unlatched address, memory strobes, upper byte enable, refresh, reset, tc.
 assumes a core-side request port synchronous to clock; the oscillator
 only approximates 14.31818 MHz since 50 MHz cannot divide to it exactly.
*/
`timescale 1ns/1ps
`include "isab_defs.vh"
module isab_mem_cycle (
	input wire clock,
	input wire rst,
	input wire clockEn,
	input wire powerFail,
	input wire reqValid,
	input wire reqWrite,
	input wire reqRefresh,
	input wire reqDma,
	input wire reqSixteen,
	input wire reqUpperByte,
	input wire [23:0] reqAddr,
	input wire dmaTermCount,
	input wire zero_wait_request_n,
	input wire extMaster,
	output reg reqReady,
	output reg cycleDone,
	output reg bclkOut,
	output reg addr_latch_strobe,
	output reg [19:0] latched_addr,
	output reg [6:0] unlatched_upper_addr,
	output reg addrOe,
	output reg upper_byte_enable_n,
	output reg mem_read_n,
	output reg mem_write_n,
	output reg cmdOe,
	output reg low_mem_read_n,
	output reg low_mem_write_n,
	output reg refreshOut_n,
	output reg refreshOe,
	output reg channel_reset_drive,
	output reg termCountOut,
	output wire free_running_osc_out
);
	localparam ST_IDLE = 5'h01;
	localparam ST_ADDR = 5'h02;
	localparam ST_CMD = 5'h04;
	localparam ST_WAIT = 5'h08;
	localparam ST_END = 5'h10;

	reg [4:0] state_r;
	reg [2:0] halfCnt_r;
	reg [3:0] waitCnt_r;
	reg [7:0] rstCnt_r;
	reg isWrite_r;
	reg isRefresh_r;
	reg isDma_r;
	reg isSixteen_r;
	reg isLow_r;
	reg [23:0] addr_r;
	reg upper_r;
	wire bclkRise;
	wire bclkFall;
	wire cmdActive;

	// oscillator free-runs off the core clock, never aligned to the bus clock
	isab_osc_gen oscGen (
		.clock(clock),
		.rst(rst),
		.clockEn(clockEn),
		.oscOut(free_running_osc_out)
	);

	// equal half periods keep the bus clock at 50% duty
	always @(posedge clock) begin
		if (rst) begin
			halfCnt_r <= 3'h0;
			bclkOut <= 1'b0;
		end else if (clockEn) begin
			if (halfCnt_r == `ISAB_BCLK_HALF - 3'h1) begin
				halfCnt_r <= 3'h0;
				bclkOut <= ~bclkOut;
			end else begin
				halfCnt_r <= halfCnt_r + 3'h1;
			end
		end
	end
	assign bclkRise = (halfCnt_r == `ISAB_BCLK_HALF - 3'h1) && !bclkOut;
	assign bclkFall = (halfCnt_r == `ISAB_BCLK_HALF - 3'h1) && bclkOut;

	// channel reset stretched so cards see it for a useful time after a glitch
	always @(posedge clock) begin
		if (rst) begin
			rstCnt_r <= `ISAB_RST_HOLD;
			channel_reset_drive <= 1'b1;
		end else if (clockEn) begin
			if (powerFail) begin
				rstCnt_r <= `ISAB_RST_HOLD;
				channel_reset_drive <= 1'b1;
			end else if (rstCnt_r != 8'h00) begin
				rstCnt_r <= rstCnt_r - 8'h01;
				channel_reset_drive <= 1'b1;
			end else begin
				channel_reset_drive <= 1'b0;
			end
		end
	end

	always @(posedge clock) begin
		if (rst) begin
			termCountOut <= 1'b0;
		end else if (clockEn) begin
			termCountOut <= dmaTermCount;
		end
	end

	assign cmdActive = (state_r == ST_CMD) || (state_r == ST_WAIT);

	always @(posedge clock) begin
		if (rst) begin
			state_r <= ST_IDLE;
			waitCnt_r <= 4'h0;
			isWrite_r <= 1'b0;
			isRefresh_r <= 1'b0;
			isDma_r <= 1'b0;
			isSixteen_r <= 1'b0;
			isLow_r <= 1'b0;
			addr_r <= 24'h000000;
			upper_r <= 1'b0;
			reqReady <= 1'b0;
			cycleDone <= 1'b0;
			addr_latch_strobe <= 1'b0;
			latched_addr <= 20'h00000;
			unlatched_upper_addr <= 7'h00;
			addrOe <= 1'b0;
			upper_byte_enable_n <= 1'b1;
			mem_read_n <= 1'b1;
			mem_write_n <= 1'b1;
			cmdOe <= 1'b0;
			low_mem_read_n <= 1'b1;
			low_mem_write_n <= 1'b1;
			refreshOut_n <= 1'b1;
			refreshOe <= 1'b0;
		end else if (clockEn) begin
			cycleDone <= 1'b0;
			// ready must not hinge on reqValid, or a held request never meets a bus clock rise
			reqReady <= (state_r == ST_IDLE) && !extMaster;
			case (state_r)
			ST_IDLE: begin
				// a channel master owns the lines; host keeps off them
				addrOe <= 1'b0;
				cmdOe <= 1'b0;
				refreshOe <= 1'b0;
				if (reqValid && reqReady && bclkRise) begin
					reqReady <= 1'b0;
					isWrite_r <= reqWrite;
					isRefresh_r <= reqRefresh;
					isDma_r <= reqDma;
					isSixteen_r <= reqSixteen;
					isLow_r <= (reqAddr[23:20] == `ISAB_LOW1MB_TOP);
					addr_r <= reqAddr;
					upper_r <= reqUpperByte;
					addr_latch_strobe <= 1'b1;
					latched_addr <= reqAddr[19:0];
					unlatched_upper_addr <= reqAddr[23:17];
					addrOe <= 1'b1;
					cmdOe <= 1'b1;
					upper_byte_enable_n <= ~reqUpperByte;
					refreshOut_n <= ~reqRefresh;
					refreshOe <= 1'b1;
					state_r <= ST_ADDR;
				end
			end
			ST_ADDR: begin
				// strobe drops on the falling bus edge; dma keeps it high
				if (bclkFall) begin
					addr_latch_strobe <= isDma_r;
					// 8-bit commands open on a falling edge, address already stable
					mem_read_n <= isWrite_r;
					mem_write_n <= ~isWrite_r;
					low_mem_read_n <= ~(~isWrite_r & isLow_r);
					low_mem_write_n <= ~(isWrite_r & isLow_r);
					waitCnt_r <= isSixteen_r ? `ISAB_WAIT16 : `ISAB_WAIT8;
					state_r <= ST_CMD;
				end
			end
			ST_CMD: begin
				state_r <= ST_WAIT;
			end
			ST_WAIT: begin
				if (bclkFall) begin
					// zero-wait from a card cuts the remaining wait cycles
					if (!zero_wait_request_n || waitCnt_r == 4'h0) begin
						mem_read_n <= 1'b1;
						mem_write_n <= 1'b1;
						low_mem_read_n <= 1'b1;
						low_mem_write_n <= 1'b1;
						state_r <= ST_END;
					end else begin
						waitCnt_r <= waitCnt_r - 4'h1;
					end
				end
			end
			ST_END: begin
				// address held past the command edge, then lines are released
				if (bclkRise) begin
					addr_latch_strobe <= 1'b0;
					upper_byte_enable_n <= 1'b1;
					refreshOut_n <= 1'b1;
					cycleDone <= 1'b1;
					state_r <= ST_IDLE;
				end
			end
			default: begin
				state_r <= ST_IDLE;
			end
			endcase
		end
	end
endmodule // isab_mem_cycle

// file: verif/isab_card_model.sv
/*
 card model: answers zero-wait from its address decode and the command.
 assumes the host bus clock and strobes come straight from the sequencer.
*/
`timescale 1ns/1ps
module isab_card_model #(parameter logic [6:0] DEC_HIT = 7'h01) (
	input wire logic bclkOut,
	input wire logic addr_latch_strobe,
	input wire logic mem_read_n,
	input wire logic mem_write_n,
	input wire logic [6:0] unlatched_upper_addr,
	input wire logic [1:0] cardMode,
	output wire logic zero_wait_request_n
);
	logic hit;
	logic late_r = 1'b0;
	logic decHit_r = 1'b0;
	// upper lines are only trusted while the strobe is high, so the decode is latched
	always @(negedge addr_latch_strobe) decHit_r <= (unlatched_upper_addr == DEC_HIT);
	assign hit = (addr_latch_strobe ? (unlatched_upper_addr == DEC_HIT) : decHit_r)
		&& !(mem_read_n && mem_write_n);
	// a slow card waits until the first bus clock rise after the command
	always @(posedge bclkOut or negedge hit) late_r <= hit;
	// released line is driven high, standing in for the pull-up level
	assign zero_wait_request_n = !(hit && (cardMode == 2'h1 || (cardMode == 2'h2 && late_r)));
endmodule // isab_card_model

// file: verif/isab_mem_cycle_sva.sv
/*
 port-level assertions for the channel memory cycle sequencer.
 assumes one clock domain and clockEn held high while cycles run.
*/
`timescale 1ns/1ps
module isab_mem_cycle_sva (
	input wire logic clock,
	input wire logic rst,
	input wire logic clockEn,
	input wire logic dmaTermCount,
	input wire logic zero_wait_request_n,
	input wire logic bclkOut,
	input wire logic [19:0] latched_addr,
	input wire logic [6:0] unlatched_upper_addr,
	input wire logic mem_read_n,
	input wire logic mem_write_n,
	input wire logic low_mem_read_n,
	input wire logic low_mem_write_n,
	input wire logic refreshOut_n,
	input wire logic refreshOe,
	input wire logic channel_reset_drive,
	input wire logic termCountOut,
	input wire logic free_running_osc_out
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	a_low_read_gate: assert property (!low_mem_read_n |-> !mem_read_n && unlatched_upper_addr[6:3] == 4'h0) else $error("low read strobe outside low space");
	a_low_write_gate: assert property (!low_mem_write_n |-> !mem_write_n && unlatched_upper_addr[6:3] == 4'h0) else $error("low write strobe outside low space");
	a_cmd_on_fall: assert property ($fell(mem_read_n) || $fell(mem_write_n) |-> !bclkOut) else $error("command not on bus clock fall");
	a_tc_echo: assert property (dmaTermCount && clockEn |=> termCountOut) else $error("terminal count pulse missing");
	a_reset_stretch: assert property ($fell(rst) |-> channel_reset_drive) else $error("channel reset not driven");
	a_addr_hold: assert property (!mem_read_n && !$past(mem_read_n) |-> $stable(latched_addr)) else $error("address moved in command");
	a_refresh_drive: assert property (!refreshOut_n |-> refreshOe) else $error("refresh low but not driven");
	a_zero_wait_end: assert property (!mem_read_n && !zero_wait_request_n |-> ##[0:9] mem_read_n) else $error("zero wait ignored");
	a_bclk_duty: assert property ($rose(bclkOut) && clockEn |-> bclkOut [*4] ##1 !bclkOut) else $error("bus clock duty wrong");
	a_osc_rate: assert property ($changed(free_running_osc_out) |-> ##[1:2] $changed(free_running_osc_out)) else $error("oscillator rate wrong");
endmodule // isab_mem_cycle_sva
bind isab_mem_cycle isab_mem_cycle_sva u_sva (.*);

// file: verif/isab_mem_cycle_tb_top.sv
/*
 self-checking bench for the channel memory cycle sequencer.
 assumes the card model decodes unlatched address 7'h01.
*/
`timescale 1ns/1ps
module isab_mem_cycle_tb_top;
	logic clock = 1'b0, rst = 1'b1, clockEn = 1'b1, powerFail = 1'b0, reqValid = 1'b0;
	logic reqWrite = 1'b0, reqRefresh = 1'b0, reqDma = 1'b0, reqSixteen = 1'b0, reqUpperByte = 1'b0;
	logic dmaTermCount = 1'b0, extMaster = 1'b0;
	logic [23:0] reqAddr = 24'h000000;
	logic [1:0] cardMode = 2'h0;
	wire zero_wait_request_n, reqReady, cycleDone, bclkOut, addr_latch_strobe, addrOe, cmdOe;
	wire upper_byte_enable_n, mem_read_n, mem_write_n, low_mem_read_n, low_mem_write_n;
	wire refreshOut_n, refreshOe, channel_reset_drive, termCountOut, free_running_osc_out;
	wire [19:0] latched_addr;
	wire [6:0] unlatched_upper_addr;
	int n_errors = 0, cmp_count = 0, cyc = 0, lastLen = 0;
	isab_mem_cycle dut (.*);
	isab_card_model card (.*);
	always #10 clock = ~clock;
	// ceiling far above the roughly twelve hundred cycles the run needs
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_errors++;
			wrap_up();
		end
	end
	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up;
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic t_reset;
		repeat (5) @(negedge clock);
		rst = 1'b0;
		chk(20'(channel_reset_drive), 20'h1);
		repeat (260) @(negedge clock);
		chk(20'(channel_reset_drive), 20'h0);
		powerFail = 1'b1;
		@(negedge clock);
		powerFail = 1'b0;
		repeat (2) @(negedge clock);
		chk(20'(channel_reset_drive), 20'h1);
		repeat (260) @(negedge clock);
	endtask
	task automatic run_cyc(input logic w, s, d, r, u, input logic [23:0] a, input logic [1:0] m);
		int n;
		n = 0;
		lastLen = 0;
		cardMode = m;
		{reqWrite, reqSixteen, reqDma, reqRefresh, reqUpperByte, reqAddr} = {w, s, d, r, u, a};
		reqValid = 1'b1;
		while (cycleDone !== 1'b1 && n < 400) begin
			@(negedge clock);
			n++;
			if (addr_latch_strobe === 1'b1) reqValid = 1'b0;
			if ((w ? mem_write_n : mem_read_n) === 1'b0) begin
				lastLen++;
				chk(20'(w ? low_mem_write_n : low_mem_read_n), 20'(a[23:20] != 4'h0));
				chk(20'(w ? mem_read_n : mem_write_n), 20'h1);
				chk(latched_addr, a[19:0]);
				chk(20'({addrOe, cmdOe}), 20'h3);
				chk(20'(unlatched_upper_addr), 20'(a[23:17]));
				chk(20'(upper_byte_enable_n), 20'(!u));
				chk(20'(refreshOut_n), 20'(!r));
				if (d) chk(20'(addr_latch_strobe), 20'h1);
			end
		end
		chk(20'(lastLen > 0 && n < 400), 20'h1);
		repeat (3) @(negedge clock);
		chk(20'({addrOe, cmdOe, refreshOe}), 20'h0);
	endtask
	task automatic t_master;
		extMaster = 1'b1;
		repeat (2) @(negedge clock);
		chk(20'(reqReady), 20'h0);
		reqValid = 1'b1;
		// a held request spans several bus clock rises and must still be refused
		repeat (20) @(negedge clock);
		chk(20'(addr_latch_strobe), 20'h0);
		chk(20'({addrOe, cmdOe}), 20'h0);
		reqValid = 1'b0;
		extMaster = 1'b0;
		repeat (2) @(negedge clock);
		chk(20'(reqReady), 20'h1);
	endtask
	task automatic t_rw;
		for (int i = 0; i < 8; i++) begin
			run_cyc(i[0], i[1], 1'b0, 1'b0, i[2], {i[2:1], 22'h0ACE5}, 2'h0);
		end
	endtask
	task automatic t_zero;
		int l0;
		run_cyc(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 24'h021234, 2'h0);
		l0 = lastLen;
		run_cyc(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 24'h021234, 2'h2);
		chk(20'(lastLen < l0), 20'h1);
		run_cyc(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 24'h021234, 2'h1);
		chk(20'(lastLen < l0), 20'h1);
		run_cyc(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 24'h02F00D, 2'h1);
	endtask
	task automatic t_dma_tc;
		run_cyc(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 24'hFEDCBA, 2'h0);
		dmaTermCount = 1'b1;
		@(negedge clock);
		dmaTermCount = 1'b0;
		chk(20'(termCountOut), 20'h1);
		@(negedge clock);
		chk(20'(termCountOut), 20'h0);
	endtask
	task automatic t_osc;
		int n;
		logic last;
		n = 0;
		last = free_running_osc_out;
		// 70 cycles span about 40 oscillator half periods
		repeat (70) begin
			@(negedge clock);
			if (free_running_osc_out !== last) n++;
			last = free_running_osc_out;
		end
		chk(20'(n >= 39 && n <= 41), 20'h1);
	endtask
	initial begin
		t_reset();
		t_master();
		t_rw();
		t_zero();
		t_dma_tc();
		t_osc();
		wrap_up();
	end
endmodule // isab_mem_cycle_tb_top
